// ---- common/dac_i2c_params.svh ----
/*
 * Constants for the octal converter's two-wire write slave and its master:
 * address map, command codes, sizes and bus timing.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef DAC_I2C_PARAMS_SVH
`define DAC_I2C_PARAMS_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define DAC_NUM_CH        8
`define DAC_RES           12
`define DAC_DATA_BYTES    3
`define DAC_WORD_BITS     16

// ----------------------------------------------------------------------
// addressing
// ----------------------------------------------------------------------
`define DAC_ADDR_PINS     3
`define DAC_ADDR_BASE     3'h1
`define DAC_GLOBAL_ADDR   7'h73
`define DAC_CHAN_ALL      4'hF

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define DAC_CMD_WR_IN     4'h0
`define DAC_CMD_UPD       4'h1
`define DAC_CMD_WR_UPD_ALL 4'h2
`define DAC_CMD_WR_UPD    4'h3
`define DAC_CMD_PD        4'h4
`define DAC_CMD_PD_CHIP   4'h5
`define DAC_CMD_REF_INT   4'h6
`define DAC_CMD_REF_EXT   4'h7
`define DAC_CMD_NOP       4'hF

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 25
`define SCL_PERIOD_NS     10000
`define SCL_QTR_CYC \
    ((`SCL_PERIOD_NS / 4 + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// ---- common/dac_i2c_pkg.sv ----
/*
 * Types shared by both ends of the converter's two-wire link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dac_i2c_pkg;

    // resolved level of a three-state chip-address strap
    typedef enum logic [1:0] {
        PIN_LOW   = 2'h0,
        PIN_FLOAT = 2'h1,
        PIN_HIGH  = 2'h2
    } ca_level_t;

    // power-on flavour of the part
    typedef enum logic [1:0] {
        POR_ZERO    = 2'h0,
        POR_MID_INT = 2'h1,
        POR_MID_EXT = 2'h2
    } por_mode_t;

    typedef enum logic [3:0] {
        S_IDLE   = 4'h1,
        S_ADDR   = 4'h2,
        S_DATA   = 4'h4,
        S_IGNORE = 4'h8
    } slv_state_t;

    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_START = 4'h2,
        M_XFER  = 4'h4,
        M_STOP  = 4'h8
    } mst_state_t;

endpackage

// ---- common/dac_i2c_if.sv ----
/*
 * Open-drain two-wire bus between the master end and the converter end.
 * Assumes each end drives a line only low; the wire level is resolved here.
 */
`timescale 1ns/1ps
interface dac_i2c_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // a released line is pulled high; any enabled low driver wins
    assign scl = m_scl_oe ? m_scl_o : 1'b1;
    assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

    modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
                    input scl, sda);
    modport slave  (output s_sda_o, s_sda_oe,
                    input scl, sda);
endinterface

// ---- src/dac_i2c_slave.sv ----
/*
 * Converter end: write-only two-wire slave plus the eight channel code,
 * power-down and reference-mode registers it steers.
 * Assumes the bus lines come from outside the sys_clk domain and that
 * sys_clk is far faster than the bus clock; rst_n stands for power-on.
 */
`timescale 1ns/1ps
`include "dac_i2c_params.svh"
module dac_i2c_slave #(
    parameter int                    RES        = `DAC_RES,
    parameter int                    ADDR_PINS  = `DAC_ADDR_PINS,
    parameter dac_i2c_pkg::por_mode_t POR_MODE  = dac_i2c_pkg::POR_ZERO
) (
    // clock and reset
    input  wire logic                             sys_clk,
    input  wire logic                             rst_n,
    // bus pins
    dac_i2c_if.slave                              bus,
    // chip-address straps
    input  wire dac_i2c_pkg::ca_level_t           chip_addr_pin_0,
    input  wire dac_i2c_pkg::ca_level_t           chip_addr_pin_1,
    input  wire dac_i2c_pkg::ca_level_t           chip_addr_pin_2,
    // analog-side state
    output logic [`DAC_NUM_CH-1:0][RES-1:0]       channel_outputs,
    output logic [`DAC_NUM_CH-1:0]                chan_powered_down,
    output logic                                  ref_internal,
    output logic                                  ref_powered_down,
    output logic                                  word_exec
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (RES != 12 && RES != 10 && RES != 8) begin : bad_res
        $error("resolution must be 12, 10 or 8");
    end
    if (ADDR_PINS != 1 && ADDR_PINS != 3) begin : bad_pins
        $error("address pin count must be 1 or 3");
    end

    localparam logic [RES-1:0] MID_CODE  = {1'b1, {(RES-1){1'b0}}};
    localparam logic [RES-1:0] POR_CODE  =
        (POR_MODE == dac_i2c_pkg::POR_ZERO) ? '0 : MID_CODE;
    localparam logic           POR_REF_INT =
        (POR_MODE != dac_i2c_pkg::POR_MID_EXT);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // strap index counts in base three, pin 2 most significant
    function automatic logic [6:0] strap_addr(input logic [4:0] idx);
        logic [2:0] hi;
        hi = idx[4:2] + `DAC_ADDR_BASE;
        return {hi, 2'b00, idx[1:0]};
    endfunction

    function automatic logic [4:0] tri_val(input logic [1:0] lvl);
        return {3'h0, lvl};
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // [0] is the metastable stage, [1] the clean level, [2] its history
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic [1:0] ca0_s1_q, ca1_s1_q, ca2_s1_q;
    logic [1:0] ca0_s2_q, ca1_s2_q, ca2_s2_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], bus.scl};
            sda_sync_q <= {sda_sync_q[1:0], bus.sda};
        end
    end

    // straps may float around reset, so they are sampled continuously
    always_ff @(posedge sys_clk) begin
        ca0_s1_q <= chip_addr_pin_0;
        ca1_s1_q <= chip_addr_pin_1;
        ca2_s1_q <= chip_addr_pin_2;
        ca0_s2_q <= ca0_s1_q;
        ca1_s2_q <= ca1_s1_q;
        ca2_s2_q <= ca2_s1_q;
    end

    wire        scl_now   = scl_sync_q[1];
    wire        scl_was   = scl_sync_q[2];
    wire        sda_now   = sda_sync_q[1];
    wire        sda_was   = sda_sync_q[2];
    wire        scl_rise  = scl_now & ~scl_was;
    wire        scl_fall  = ~scl_now & scl_was;
    wire        start_det = scl_now & scl_was & sda_was & ~sda_now;
    wire        stop_det  = scl_now & scl_was & ~sda_was & sda_now;

    wire [4:0]  idx_hi    = (ADDR_PINS == 3) ?
                            5'(tri_val(ca2_s2_q) * 5'd9 +
                               tri_val(ca1_s2_q) * 5'd3) : 5'h0;
    wire [4:0]  strap_idx = 5'(idx_hi + tri_val(ca0_s2_q));
    wire [6:0]  own_addr  = strap_addr(strap_idx);

    // ------------------------------------------------------------------
    // byte receiver
    // ------------------------------------------------------------------
    dac_i2c_pkg::slv_state_t state_q;
    logic [3:0]  bit_cnt_q;
    logic [1:0]  byte_cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  cmd_q;
    logic [15:0] data_q;
    logic        ack_oe_q;
    logic        exec_q;

    wire        in_frame  = (state_q != dac_i2c_pkg::S_IDLE);
    wire        byte_done = scl_fall & (bit_cnt_q == 4'd8);
    wire        addr_hit  = (shift_q[7:1] == own_addr) |
                            (shift_q[7:1] == `DAC_GLOBAL_ADDR);
    wire        addr_wr   = ~shift_q[0];
    wire        addr_ack  = addr_hit & addr_wr;
    wire        data_ack  = (byte_cnt_q != 2'(`DAC_DATA_BYTES));
    wire        last_byte = (byte_cnt_q == 2'(`DAC_DATA_BYTES - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q    <= dac_i2c_pkg::S_IDLE;
            bit_cnt_q  <= 4'h0;
            byte_cnt_q <= 2'h0;
            shift_q    <= 8'h00;
            cmd_q      <= 8'hFF;
            data_q     <= 16'h0000;
            ack_oe_q   <= 1'b0;
            exec_q     <= 1'b0;
        end else begin
            exec_q <= 1'b0;
            if (start_det || stop_det) begin
                state_q    <= start_det ? dac_i2c_pkg::S_ADDR
                                        : dac_i2c_pkg::S_IDLE;
                bit_cnt_q  <= 4'h0;
                byte_cnt_q <= 2'h0;
                ack_oe_q   <= 1'b0;
            end else if (in_frame) begin
                if (scl_rise) begin
                    if (bit_cnt_q == 4'd8) begin
                        bit_cnt_q <= 4'h0;
                    end else begin
                        shift_q   <= {shift_q[6:0], sda_now};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                // release after the ack pulse ends
                if (scl_fall && ack_oe_q && bit_cnt_q == 4'h0) begin
                    ack_oe_q <= 1'b0;
                end
                if (byte_done) begin
                    case (state_q)
                        dac_i2c_pkg::S_ADDR: begin
                            ack_oe_q <= addr_ack;
                            state_q  <= addr_ack ? dac_i2c_pkg::S_DATA
                                                 : dac_i2c_pkg::S_IGNORE;
                        end
                        dac_i2c_pkg::S_DATA: begin
                            ack_oe_q <= data_ack;
                            if (data_ack) begin
                                byte_cnt_q <= byte_cnt_q + 2'h1;
                                if (byte_cnt_q == 2'h0) begin
                                    cmd_q <= shift_q;
                                end else begin
                                    data_q <= {data_q[7:0], shift_q};
                                end
                                exec_q <= last_byte;
                            end
                        end
                        default: ack_oe_q <= 1'b0;
                    endcase
                end
            end
        end
    end

    // open drain: only ever a low, and only in an ack slot
    assign bus.s_sda_o  = 1'b0;
    assign bus.s_sda_oe = ack_oe_q;
    assign word_exec    = exec_q;

    // ------------------------------------------------------------------
    // command execution
    // ------------------------------------------------------------------
    wire [3:0]      cmd      = cmd_q[7:4];
    wire [3:0]      chan     = cmd_q[3:0];
    wire [RES-1:0]  new_code = data_q[15 -: RES];
    wire            to_all   = (chan == `DAC_CHAN_ALL);
    wire            is_wr    = (cmd == `DAC_CMD_WR_IN) |
                               (cmd == `DAC_CMD_WR_UPD_ALL) |
                               (cmd == `DAC_CMD_WR_UPD);
    wire            is_upd   = (cmd == `DAC_CMD_UPD) |
                               (cmd == `DAC_CMD_WR_UPD);
    wire            upd_all  = exec_q & (cmd == `DAC_CMD_WR_UPD_ALL);
    wire            pd_chip  = exec_q & (cmd == `DAC_CMD_PD_CHIP);

    logic [`DAC_NUM_CH-1:0][RES-1:0] in_q;
    logic [`DAC_NUM_CH-1:0][RES-1:0] dac_q;
    logic [`DAC_NUM_CH-1:0]          pd_q;

    for (genvar ch = 0; ch < `DAC_NUM_CH; ch++) begin : g_chan
        wire sel    = to_all | (chan == 4'(ch));
        wire wr_in  = exec_q & sel & is_wr;
        wire upd    = (exec_q & sel & is_upd) | upd_all;
        // power-down leaves both code registers untouched
        wire pd_cmd = (exec_q & sel & (cmd == `DAC_CMD_PD)) | pd_chip;

        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                in_q[ch]  <= POR_CODE;
                dac_q[ch] <= POR_CODE;
                pd_q[ch]  <= 1'b0;
            end else begin
                if (wr_in) begin
                    in_q[ch] <= new_code;
                end
                if (upd) begin
                    dac_q[ch] <= wr_in ? new_code : in_q[ch];
                    pd_q[ch]  <= 1'b0;
                end else if (pd_cmd) begin
                    pd_q[ch] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // reference mode
    // ------------------------------------------------------------------
    logic ref_int_q;
    logic ref_pd_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ref_int_q <= POR_REF_INT;
            ref_pd_q  <= 1'b0;
        end else if (exec_q) begin
            case (cmd)
                `DAC_CMD_REF_INT: begin
                    ref_int_q <= 1'b1;
                    ref_pd_q  <= 1'b0;
                end
                `DAC_CMD_REF_EXT: ref_int_q <= 1'b0;
                `DAC_CMD_PD_CHIP: ref_pd_q  <= 1'b1;
                default:          ref_pd_q  <= ref_pd_q;
            endcase
        end
    end

    // the analog stage scales each code by 2**RES against the selected
    // reference; only the digital code and mode leave this block
    assign channel_outputs   = dac_q;
    assign chan_powered_down = pd_q;
    assign ref_internal      = ref_int_q;
    assign ref_powered_down  = ref_pd_q;

endmodule

// ---- src/dac_i2c_master.sv ----
/*
 * Master end: sends one write (address plus three data bytes, optionally
 * a fourth) or a bare read address, then a stop.
 * Assumes the slave never stretches the clock; the bus clock is made
 * here from sys_clk by a quarter-period divider.
 */
`timescale 1ns/1ps
`include "dac_i2c_params.svh"
module dac_i2c_master #(
    parameter int QTR_CYC = `SCL_QTR_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // bus pins
    dac_i2c_if.master        bus,
    // request
    input  wire logic        req,
    output logic             ready,
    input  wire logic [6:0]  req_addr,
    input  wire logic        req_read,
    input  wire logic        req_extra,
    input  wire logic [23:0] req_word,
    // answer
    output logic             done,
    output logic             nak
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (QTR_CYC < 8 || QTR_CYC > 65535) begin : bad_qtr
        $error("quarter period must be 8 to 65535 cycles");
    end

    localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

    // ------------------------------------------------------------------
    // timing and sync
    // ------------------------------------------------------------------
    logic [15:0] qcnt_q;
    logic [1:0]  sda_sync_q;
    wire         tick = (qcnt_q == QTR_LAST);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            qcnt_q     <= 16'h0000;
            sda_sync_q <= 2'h3;
        end else begin
            qcnt_q     <= tick ? 16'h0000 : qcnt_q + 16'h0001;
            sda_sync_q <= {sda_sync_q[0], bus.sda};
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    dac_i2c_pkg::mst_state_t state_q;
    logic [1:0]  phase_q;
    logic [3:0]  bit_q;
    logic [2:0]  byte_q;
    logic [7:0]  tx_q;
    logic [23:0] word_q;
    logic        read_q;
    logic        extra_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        nak_q;
    logic        done_q;

    wire         idle     = (state_q == dac_i2c_pkg::M_IDLE);
    wire         ack_bit  = (bit_q == 4'd8);
    wire         got_nak  = sda_sync_q[1];
    wire [2:0]   n_bytes  = extra_q ? 3'd4 : 3'd3;
    wire         finish   = got_nak | read_q | (byte_q == n_bytes);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q  <= dac_i2c_pkg::M_IDLE;
            phase_q  <= 2'h0;
            bit_q    <= 4'h0;
            byte_q   <= 3'h0;
            tx_q     <= 8'h00;
            word_q   <= 24'h000000;
            read_q   <= 1'b0;
            extra_q  <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            nak_q    <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                dac_i2c_pkg::M_IDLE: begin
                    if (req) begin
                        state_q <= dac_i2c_pkg::M_START;
                        phase_q <= 2'h0;
                        tx_q    <= {req_addr, req_read};
                        word_q  <= req_word;
                        read_q  <= req_read;
                        extra_q <= req_extra;
                        nak_q   <= 1'b0;
                    end
                end
                dac_i2c_pkg::M_START: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    // data falls while the clock is high
                    if (phase_q == 2'h1) sda_oe_q <= 1'b1;
                    if (phase_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        state_q  <= dac_i2c_pkg::M_XFER;
                        bit_q    <= 4'h0;
                        byte_q   <= 3'h0;
                    end
                end
                dac_i2c_pkg::M_XFER: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        // released for the ack slot
                        2'h0: sda_oe_q <= ack_bit ? 1'b0 : ~tx_q[7];
                        2'h2: scl_oe_q <= 1'b0;
                        2'h3: begin
                            scl_oe_q <= 1'b1;
                            if (!ack_bit) begin
                                tx_q  <= {tx_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end else if (finish) begin
                                nak_q   <= got_nak;
                                state_q <= dac_i2c_pkg::M_STOP;
                            end else begin
                                bit_q  <= 4'h0;
                                byte_q <= byte_q + 3'h1;
                                tx_q   <= (byte_q == 3'd3) ? 8'hFF
                                                           : word_q[23:16];
                                word_q <= {word_q[15:0], 8'h00};
                            end
                        end
                        default: sda_oe_q <= sda_oe_q;
                    endcase
                end
                dac_i2c_pkg::M_STOP: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sda_oe_q <= 1'b1;
                        2'h1: scl_oe_q <= 1'b0;
                        // data rises while the clock is high
                        2'h2: sda_oe_q <= 1'b0;
                        default: begin
                            state_q <= dac_i2c_pkg::M_IDLE;
                            done_q  <= 1'b1;
                        end
                    endcase
                end
                default: state_q <= dac_i2c_pkg::M_IDLE;
            endcase
        end
    end

    // both lines released between frames
    assign bus.m_scl_o  = 1'b0;
    assign bus.m_scl_oe = scl_oe_q;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = sda_oe_q;
    assign ready        = idle;
    assign done         = done_q;
    assign nak          = nak_q;

endmodule

// ---- verif/dac_i2c_link_chk.sv ----
/*
 * Concurrent checks on the two-wire link between master and slave ends.
 * Assumes the master runs with a quarter period of 8 sys_clk cycles.
 */
`timescale 1ns/1ps
module dac_i2c_link_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // resolved and driven bus lines
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // acknowledge slot, clock high time, start and stop
    // ------------------------------------------------------------------
    chk_ack_rise_low: assert property ($rose(s_sda_oe) |-> !scl)
        else $error("slave data drive began while clock high");
    chk_ack_fall_low: assert property ($fell(s_sda_oe) |-> !scl)
        else $error("slave data drive ended while clock high");
    // one bit time is four quarters, so the drive spans about 32 cycles
    chk_ack_span: assert property (
        $rose(s_sda_oe) |-> s_sda_oe[*8] ##20 s_sda_oe ##[1:6] !s_sda_oe)
        else $error("acknowledge drive length wrong");
    chk_bit_stable: assert property (
        $rose(scl) |-> $stable(s_sda_oe)[*4])
        else $error("slave data drive moved around clock rise");
    chk_ack_master_off: assert property (
        (s_sda_oe && scl) |-> !m_sda_oe)
        else $error("master drives data during acknowledge");
    chk_clock_high: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high period too short");
    chk_start_free: assert property (
        (scl && $fell(sda)) |-> !s_sda_oe)
        else $error("slave holds data at start");
    chk_stop_free: assert property (
        (scl && $rose(sda)) |=> !s_sda_oe[*8])
        else $error("slave drives data after stop");
endmodule

// ---- verif/tb_octal_dac_i2c_write_slave.sv ----
/*
 * Self-checking bench: master end drives frames into the slave end.
 * Assumes both design ends and the shared link interface are compiled.
 */
`timescale 1ns/1ps
module tb_octal_dac_i2c_write_slave;
    logic                   sys_clk = 1'h0;
    logic                   rst_n = 1'h0;
    logic                   req = 1'h0;
    logic                   ready;
    logic [6:0]             req_addr = 7'h00;
    logic                   req_read = 1'h0;
    logic                   req_extra = 1'h0;
    logic [23:0]            req_word = 24'h000000;
    logic                   done;
    logic                   nak;
    dac_i2c_pkg::ca_level_t ca0 = dac_i2c_pkg::PIN_HIGH;
    dac_i2c_pkg::ca_level_t ca1 = dac_i2c_pkg::PIN_FLOAT;
    dac_i2c_pkg::ca_level_t ca2 = dac_i2c_pkg::PIN_LOW;
    logic [7:0][11:0]       codes;
    logic [7:0]             pd;
    logic                   ref_int;
    logic                   ref_pd;
    logic [7:0][11:0]       codes_mi;
    logic [7:0][11:0]       codes_mx;
    logic                   ref_mi;
    logic                   ref_mx;
    logic                   exec_w;
    logic                   mst_en = 1'h1;
    int                     n_exec = 0;
    int                     err_count = 0;
    int                     n_checks = 0;

    always #12.5 sys_clk = ~sys_clk;
    dac_i2c_if link ();
    dac_i2c_master #(.QTR_CYC(8)) dac_i2c_master_inst (.sys_clk(sys_clk),
        .rst_n(rst_n & mst_en), .bus(link.master), .req(req), .ready(ready),
        .req_addr(req_addr), .req_read(req_read), .req_extra(req_extra),
        .req_word(req_word), .done(done), .nak(nak));
    dac_i2c_slave dac_i2c_slave_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(link.slave), .chip_addr_pin_0(ca0), .chip_addr_pin_1(ca1),
        .chip_addr_pin_2(ca2), .channel_outputs(codes),
        .chan_powered_down(pd), .ref_internal(ref_int),
        .ref_powered_down(ref_pd), .word_exec(exec_w));
    // idle copies of the other power-on flavours; only reset is looked at
    dac_i2c_if idle_mi ();
    dac_i2c_if idle_mx ();
    assign idle_mi.m_scl_o  = 1'h0;
    assign idle_mi.m_scl_oe = 1'h0;
    assign idle_mi.m_sda_o  = 1'h0;
    assign idle_mi.m_sda_oe = 1'h0;
    assign idle_mx.m_scl_o  = 1'h0;
    assign idle_mx.m_scl_oe = 1'h0;
    assign idle_mx.m_sda_o  = 1'h0;
    assign idle_mx.m_sda_oe = 1'h0;
    dac_i2c_slave #(.POR_MODE(dac_i2c_pkg::POR_MID_INT))
        dac_i2c_slave_mi_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(idle_mi.slave), .chip_addr_pin_0(ca0), .chip_addr_pin_1(ca1),
        .chip_addr_pin_2(ca2), .channel_outputs(codes_mi),
        .chan_powered_down(), .ref_internal(ref_mi),
        .ref_powered_down(), .word_exec());
    dac_i2c_slave #(.POR_MODE(dac_i2c_pkg::POR_MID_EXT))
        dac_i2c_slave_mx_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(idle_mx.slave), .chip_addr_pin_0(ca0), .chip_addr_pin_1(ca1),
        .chip_addr_pin_2(ca2), .channel_outputs(codes_mx),
        .chan_powered_down(), .ref_internal(ref_mx),
        .ref_powered_down(), .word_exec());

    // every executed word shows as one pulse
    always @(negedge sys_clk) begin
        if (exec_w === 1'h1) begin
            n_exec++;
        end
    end
    dac_i2c_link_chk dac_i2c_link_chk_inst (.sys_clk(sys_clk),
        .rst_n(rst_n), .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe),
        .scl(link.scl), .sda(link.sda));

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one frame; the request is dropped after the edge that takes it
    task automatic send(input logic [6:0] a, input logic rd, input logic ex,
                        input logic [23:0] w, input logic exp_nak);
        int i;
        @(negedge sys_clk);
        req_addr = a;
        req_read = rd;
        req_extra = ex;
        req_word = w;
        req = 1'h1;
        @(negedge sys_clk);
        req = 1'h0;
        for (i = 0; i < 4000 && done !== 1'h1; i++) @(negedge sys_clk);
        if (i == 4000) begin
            err_count++;
            $display("BAD %0t frame timed out", $time);
        end
        check_val({11'h000, nak}, {11'h000, exp_nak});
        check_val({11'h000, ready}, 12'h001);
    endtask

    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'h1;
        repeat (4) @(negedge sys_clk);
        check_val(codes[0], 12'h000);
        check_val(codes_mi[0], 12'h800);
        check_val({11'h000, ref_mi}, 12'h001);
        check_val(codes_mx[7], 12'h800);
        check_val({11'h000, ref_mx}, 12'h000);
        send(7'h21, 1'h0, 1'h0, 24'h32ABC0, 1'h0);
        check_val(codes[2], 12'hABC);
        send(7'h21, 1'h1, 1'h0, 24'h000000, 1'h1);
        send(7'h22, 1'h0, 1'h0, 24'h33FFF0, 1'h1);
        check_val(codes[3], 12'h000);
        send(7'h21, 1'h0, 1'h1, 24'h311230, 1'h1);
        check_val(codes[1], 12'h123);
        send(7'h73, 1'h0, 1'h0, 24'h3F5550, 1'h0);
        check_val(codes[7], 12'h555);
        send(7'h21, 1'h0, 1'h0, 24'h051110, 1'h0);
        check_val(codes[5], 12'h555);
        send(7'h21, 1'h0, 1'h0, 24'h150000, 1'h0);
        check_val(codes[5], 12'h111);
        send(7'h21, 1'h0, 1'h0, 24'h262220, 1'h0);
        check_val(codes[6], 12'h222);
        send(7'h21, 1'h0, 1'h0, 24'h40FFF0, 1'h0);
        check_val({4'h0, pd}, 12'h001);
        check_val(codes[0], 12'h555);
        send(7'h21, 1'h0, 1'h0, 24'h700000, 1'h0);
        check_val({11'h000, ref_int}, 12'h000);
        send(7'h21, 1'h0, 1'h0, 24'h600000, 1'h0);
        check_val({11'h000, ref_int}, 12'h001);
        send(7'h21, 1'h0, 1'h0, 24'h5F1230, 1'h0);
        check_val({3'h0, ref_pd, pd}, 12'h1FF);
        // master dropped mid-address; the next start must resync
        @(negedge sys_clk);
        req_word = 24'h357770;
        req = 1'h1;
        @(negedge sys_clk);
        req = 1'h0;
        repeat (100) @(negedge sys_clk);
        mst_en = 1'h0;
        repeat (4) @(negedge sys_clk);
        mst_en = 1'h1;
        send(7'h21, 1'h0, 1'h0, 24'h353330, 1'h0);
        check_val(codes[5], 12'h333);
        ca0 = dac_i2c_pkg::PIN_HIGH;
        ca1 = dac_i2c_pkg::PIN_HIGH;
        ca2 = dac_i2c_pkg::PIN_HIGH;
        repeat (4) @(negedge sys_clk);
        send(7'h72, 1'h0, 1'h0, 24'h3477F0, 1'h0);
        check_val(codes[4], 12'h77F);
        send(7'h21, 1'h0, 1'h0, 24'h340000, 1'h1);
        check_val(codes[4], 12'h77F);
        check_val(12'(n_exec), 12'h00C);
        give_verdict();
    end
endmodule
